// File: rtl/power_sleep_reset_sequencer.sv
// Contract
// - all logic runs on the internal oscillator clock, no external clock.
// - sleep from active only after both lines high and everything idle over two seconds.
// - in sleep the oscillator is stopped.
// - either line low wakes the device back to active.
// - during reset every register takes its defined initial value.
// - after reset release registers are loaded from one-time memory.
// - initialisation ends within 160 us, then straight into sleep.
// - reset held while supply is low, plus a fixed delay after.
`timescale 1ns/1ps
`include "psq_consts.svh"
module power_sleep_reset_sequencer
	import psq_pkg::*;
#(
	parameter int unsigned REG_WORDS = `PSQ_REG_WORDS,
	parameter int unsigned REG_W     = `PSQ_REG_W,
	parameter int unsigned SLEEP_CYC = `PSQ_SLEEP_CYC,
	parameter logic [REG_WORDS-1:0][REG_W-1:0] DEFAULTS = '0
) (
	input  wire logic                              clk_sys,
	input  wire logic                              arst_n,
	input  wire logic                              scl_in,
	input  wire logic                              sda_in,
	input  wire logic                              supply_detect_level,
	input  wire logic                              func_busy,
	input  wire logic [REG_W-1:0]                  otp_rdata,
	input  wire logic                              otp_ack,
	output logic                                   otp_rd,
	output logic      [$clog2(REG_WORDS)-1:0]      otp_addr,
	output logic      [REG_WORDS-1:0][REG_W-1:0]   cfg_regs,
	output logic                                   osc_stop,
	output logic                                   sys_rst_n,
	output status_s                                status
);

	localparam int IDX_W = $clog2(REG_WORDS);
	localparam int CNT_W = $clog2(SLEEP_CYC + 1);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic scl_s;
	logic sda_s;
	logic supply_s;

	// bus lines idle high, supply assumed low until seen
	pin_sync #(
		.W       (3),
		.RST_VAL (3'b110)
	) u_sync (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.pin_in  ({scl_in, sda_in, supply_detect_level}),
		.pin_out ({scl_s, sda_s, supply_s})
	);

	logic line_low;
	assign line_low = !scl_s || !sda_s;

	////////////////////////////////////////////////////////////////////////////
	// state and counters

	psq_state_e                 state_reg;
	psq_state_e                 state_next;
	logic [`PSQ_POR_CNT_W-1:0]  por_cnt_reg;
	logic [`PSQ_INIT_CNT_W-1:0] init_cnt_reg;
	logic [IDX_W-1:0]           load_idx_reg;
	logic [CNT_W-1:0]           idle_cnt_reg;
	logic                       por_done;
	logic                       init_timeout;
	logic                       load_last;
	logic                       idle_expired;

	assign por_done     = por_cnt_reg == `PSQ_POR_CNT_W'(`PSQ_POR_DELAY_CYC);
	assign init_timeout = init_cnt_reg == `PSQ_INIT_CNT_W'(`PSQ_INIT_MAX_CYC - 2);
	assign load_last    = otp_ack && load_idx_reg == IDX_W'(REG_WORDS - 1);
	assign idle_expired = idle_cnt_reg == CNT_W'(SLEEP_CYC);

	// reset delay counter restarts whenever the supply dips
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			por_cnt_reg <= '0;
		end else if (!supply_s) begin
			por_cnt_reg <= '0;
		end else if (state_reg == ST_HOLD && !por_done) begin
			por_cnt_reg <= por_cnt_reg + 1'b1;
		end
	end

	// next state; supply loss overrides everything
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_HOLD:    if (por_done) state_next = ST_DEFAULT;
			ST_DEFAULT: state_next = ST_LOAD;
			ST_LOAD:    if (load_last || init_timeout) state_next = ST_SLEEP;
			ST_ACTIVE:  if (idle_expired) state_next = ST_SLEEP;
			ST_SLEEP:   if (line_low) state_next = ST_ACTIVE;
			default:    state_next = ST_HOLD;
		endcase
		if (!supply_s) begin
			state_next = ST_HOLD;
		end
	end

	// one clock for everything: the internal oscillator
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_HOLD;
		end else begin
			state_reg <= state_next;
		end
	end

	// initialisation watchdog, counted only during the load step
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			init_cnt_reg <= '0;
		end else if (state_reg == ST_HOLD) begin
			init_cnt_reg <= '0;
		end else if (state_reg == ST_LOAD) begin
			init_cnt_reg <= init_cnt_reg + 1'b1;
		end
	end

	// idle timer; any line low or activity restarts it
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			idle_cnt_reg <= '0;
		end else if (state_reg != ST_ACTIVE || line_low || func_busy) begin
			idle_cnt_reg <= '0;
		end else if (!idle_expired) begin
			idle_cnt_reg <= idle_cnt_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register bank: defaults, then otp load

	// word index walks upward, one word per acknowledge
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			load_idx_reg <= '0;
		end else if (state_reg != ST_LOAD) begin
			load_idx_reg <= '0;
		end else if (otp_ack && !load_last) begin
			load_idx_reg <= load_idx_reg + 1'b1;
		end
	end

	// defaults while held or on the default step, otp words afterwards
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cfg_regs <= DEFAULTS;
		end else if (state_reg == ST_HOLD || state_reg == ST_DEFAULT) begin
			cfg_regs <= DEFAULTS;
		end else if (state_reg == ST_LOAD && otp_ack) begin
			cfg_regs[load_idx_reg] <= otp_rdata;
		end
	end

	// read request held through the whole load step; dropped after the last word or a watchdog timeout
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			otp_rd   <= 1'b0;
			otp_addr <= '0;
		end else begin
			otp_rd   <= state_next == ST_LOAD;
			otp_addr <= (state_reg == ST_LOAD && otp_ack && !load_last) ?
				load_idx_reg + 1'b1 : (state_reg == ST_LOAD ? load_idx_reg : '0);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	// stop request follows the sleep state; the oscillator cell restarts on a
	// line going low, so the block only needs to drop the request after wake
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			osc_stop  <= 1'b0;
			sys_rst_n <= 1'b0;
			status    <= '0;
		end else begin
			osc_stop         <= state_next == ST_SLEEP;
			sys_rst_n        <= state_next != ST_HOLD;
			status.sleeping  <= state_next == ST_SLEEP;
			status.active    <= state_next == ST_ACTIVE;
			if (state_next == ST_HOLD) begin
				status.init_done <= 1'b0;
				status.init_err  <= 1'b0;
			end else if (state_reg == ST_LOAD && state_next == ST_SLEEP) begin
				status.init_done <= 1'b1;
				status.init_err  <= !load_last; // watchdog cut the load short
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	// cycles spent initialising; the bound is too long for a delay range, so count it
	logic [`PSQ_INIT_CNT_W-1:0] init_age_reg;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			init_age_reg <= '0;
		end else if (state_reg != ST_DEFAULT && state_reg != ST_LOAD) begin
			init_age_reg <= '0;
		end else begin
			init_age_reg <= init_age_reg + 1'b1;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_hold_low_supply: assert property (!supply_s |=> state_reg == ST_HOLD)
		else $error("state left hold while supply low");

	a_por_delay: assert property ($rose(supply_s) |=> (state_reg == ST_HOLD) [*8])
		else $error("reset released too early after supply rise");

	a_default_load: assert property (state_reg == ST_DEFAULT |=> cfg_regs == DEFAULTS)
		else $error("registers not at defaults after default step");

	a_otp_write: assert property (state_reg == ST_LOAD && otp_ack |=>
		cfg_regs[$past(load_idx_reg)] == $past(otp_rdata))
		else $error("otp word not stored");

	a_init_bound: assert property (state_reg == ST_DEFAULT || state_reg == ST_LOAD |->
		init_age_reg < `PSQ_INIT_CNT_W'(`PSQ_INIT_MAX_CYC))
		else $error("initialisation exceeded its time bound");

	a_load_to_sleep: assert property (state_reg == ST_LOAD && load_last && supply_s |=>
		state_reg == ST_SLEEP)
		else $error("load did not end in sleep");

	a_wake_fast: assert property (state_reg == ST_SLEEP && line_low && supply_s |=>
		state_reg == ST_ACTIVE && !osc_stop)
		else $error("no wake on line low");

	a_osc_stop: assert property (osc_stop == (state_reg == ST_SLEEP))
		else $error("oscillator stop does not match sleep");

	a_sleep_idle: assert property (state_reg == ST_ACTIVE ##1 state_reg == ST_SLEEP |->
		$past(idle_cnt_reg) == CNT_W'(SLEEP_CYC))
		else $error("sleep entered before idle time");

	a_idle_restart: assert property (state_reg == ST_ACTIVE && (func_busy || line_low) |=>
		idle_cnt_reg == '0)
		else $error("idle timer not restarted");

endmodule : power_sleep_reset_sequencer

// File: rtl/psq_consts.svh
`ifndef PSQ_CONSTS_SVH
`define PSQ_CONSTS_SVH

// internal clock rate in Hz
`define PSQ_CLK_HZ        25000000
// register initialisation must end within this many microseconds
`define PSQ_INIT_MAX_US   160
// longest time rounds down to whole cycles
`define PSQ_INIT_MAX_CYC  (`PSQ_INIT_MAX_US * (`PSQ_CLK_HZ / 1000000))
// counter width for the initialisation watchdog
`define PSQ_INIT_CNT_W    12
// idle time before sleep, in milliseconds (must be exceeded)
`define PSQ_SLEEP_MS      2000
// least time rounds up; this divides evenly at 25 MHz
`define PSQ_SLEEP_CYC     (`PSQ_SLEEP_MS * (`PSQ_CLK_HZ / 1000))
// extra cycles held in reset after the supply crosses its level
`define PSQ_POR_DELAY_CYC 64
`define PSQ_POR_CNT_W     7
// configuration register bank shape
`define PSQ_REG_WORDS     8
`define PSQ_REG_W         16

`endif

// File: rtl/psq_pkg.sv
package psq_pkg;

	// sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_HOLD    = 5'b0_0001,
		ST_DEFAULT = 5'b0_0010,
		ST_LOAD    = 5'b0_0100,
		ST_ACTIVE  = 5'b0_1000,
		ST_SLEEP   = 5'b1_0000
	} psq_state_e;

	// status flags shown to the rest of the chip
	typedef struct packed {
		logic init_done;
		logic init_err;
		logic sleeping;
		logic active;
	} status_s;

endpackage : psq_pkg

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; output follows once stages two and three agree
module pin_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_sys,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_out
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// s1 feeds s2 only, to keep metastability contained
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// per-bit agreement filter
	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				pin_out[i] <= RST_VAL[i];
			end else if (s2_reg[i] == s3_reg[i]) begin
				pin_out[i] <= s3_reg[i];
			end
		end
	end

endmodule : pin_sync

// File: tb/host_otp_model.sv
`timescale 1ns/1ps
// far side: host holding the bus lines, plus the otp array answering reads
module host_otp_model (
	input  wire logic        clk_sys,
	input  wire logic        otp_rd,
	input  wire logic [2:0]  otp_addr,
	input  wire logic        slow,
	input  wire logic [1:0]  pull_low,
	input  wire logic        mute,
	output logic             scl_in,
	output logic             sda_in,
	output logic             otp_ack,
	output logic [15:0]      otp_rdata
);
	logic [1:0] gap_reg;

	initial begin
		otp_ack   = 1'b0;
		otp_rdata = 16'h0000;
		gap_reg   = 2'h0;
	end

	// open-drain lines with pull-ups: high unless the host pulls them
	assign scl_in = ~pull_low[0];
	assign sda_in = ~pull_low[1];

	// one word per ack; slow mode leaves gaps so the loader must wait
	always @(posedge clk_sys) begin
		gap_reg <= gap_reg + 2'h1;
		// a muted array never answers, so only the load watchdog can end init
		if (otp_rd && !otp_ack && !mute && (!slow || gap_reg == 2'h3)) begin
			otp_ack   <= 1'b1;
			otp_rdata <= {8'hc0 + {5'h00, otp_addr}, 8'h5a};
		end else begin
			otp_ack   <= 1'b0;
			otp_rdata <= ~otp_rdata; // stale data never holds its value
		end
	end
endmodule : host_otp_model

// File: tb/power_sleep_reset_sequencer_test.sv
`timescale 1ns/1ps
`define CHECK_EQ(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
	n_mismatch++; $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module power_sleep_reset_sequencer_test import psq_pkg::*;;
	localparam int unsigned      SLEEP_SIM = 20;
	localparam logic [7:0][15:0] DEF       = {8{16'h1234}};

	logic              clk_sys = 1'b0;
	logic              arst_n, supply, func_busy, slow, mute;
	logic [1:0]        pull_low;
	logic              scl_in, sda_in, otp_ack, otp_rd, osc_stop, sys_rst_n;
	logic [15:0]       otp_rdata;
	logic [2:0]        otp_addr;
	logic [7:0][15:0]  cfg_regs;
	status_s           status;
	int                n_mismatch = 0;
	int                n_compared = 0;

	always #20 clk_sys = ~clk_sys;

	power_sleep_reset_sequencer #(.SLEEP_CYC(SLEEP_SIM), .DEFAULTS(DEF)) dut_u (
		.clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
		.supply_detect_level(supply), .func_busy(func_busy), .otp_rdata(otp_rdata),
		.otp_ack(otp_ack), .otp_rd(otp_rd), .otp_addr(otp_addr), .cfg_regs(cfg_regs),
		.osc_stop(osc_stop), .sys_rst_n(sys_rst_n), .status(status));

	host_otp_model host_u (
		.clk_sys(clk_sys), .otp_rd(otp_rd), .otp_addr(otp_addr), .slow(slow),
		.pull_low(pull_low), .scl_in(scl_in), .sda_in(sda_in), .otp_ack(otp_ack),
		.otp_rdata(otp_rdata), .mute(mute));

	// sample just after the edge so its updates have landed
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask : tick

	task automatic summarize();
		$display("mismatches %0d of %0d compared", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	// reset forces defaults on everything driven outward
	task automatic t_reset_defaults();
		repeat (6) tick();
		`CHECK_EQ("sys_rst_n", 1'b0, sys_rst_n)
		`CHECK_EQ("osc_stop", 1'b0, osc_stop)
		`CHECK_EQ("otp_rd", 1'b0, otp_rd)
		`CHECK_EQ("cfg_regs", DEF, cfg_regs)
		`CHECK_EQ("status", 4'h0, status)
		@(posedge clk_sys) arst_n <= 1'b1;
	endtask : t_reset_defaults

	// release delay, otp load, bounded init time, then straight to sleep
	task automatic t_init(input logic slow_mode);
		int n;
		n = 0;
		@(posedge clk_sys) slow <= slow_mode;
		while (sys_rst_n !== 1'b1 && n < 300) begin
			tick();
			n++;
		end
		`CHECK_EQ("release delay ok", 1'b1, n >= 64 && n < 300)
		n = 0;
		while (status.init_done !== 1'b1 && n < 4100) begin
			tick();
			n++;
		end
		`CHECK_EQ("init within bound", 1'b1, n <= 4000)
		for (int a = 0; a < 8; a++)
			`CHECK_EQ("cfg word", {8'hc0 + 8'(a), 8'h5a}, cfg_regs[a])
		`CHECK_EQ("init_err", 1'b0, status.init_err)
		`CHECK_EQ("sleeping", 1'b1, status.sleeping)
		`CHECK_EQ("osc_stop", 1'b1, osc_stop)
		`CHECK_EQ("otp_rd after load", 1'b0, otp_rd)
	endtask : t_init

	// either line low wakes within a few sync cycles
	task automatic t_wake(input int line);
		int n;
		n = 0;
		@(posedge clk_sys) pull_low[line] <= 1'b1;
		while (osc_stop !== 1'b0 && n < 8) begin
			tick();
			n++;
		end
		`CHECK_EQ("osc_stop after wake", 1'b0, osc_stop)
		`CHECK_EQ("active after wake", 1'b1, status.active)
		@(posedge clk_sys) pull_low[line] <= 1'b0;
	endtask : t_wake

	// idle lines sleep only after the full span; a busy pulse restarts it
	task automatic t_idle_sleep(input int busy_at);
		int n;
		n = 0;
		while (osc_stop !== 1'b1 && n < 100) begin
			@(posedge clk_sys) func_busy <= (n == busy_at && busy_at > 0);
			#1;
			n++;
		end
		`CHECK_EQ("sleep not early", 1'b1, n > SLEEP_SIM + busy_at)
		`CHECK_EQ("sleep not late", 1'b1, n <= SLEEP_SIM + busy_at + 12)
		`CHECK_EQ("sleeping flag", 1'b1, status.sleeping)
	endtask : t_idle_sleep

	// low supply pulls internal reset back down
	task automatic t_supply_drop();
		int n;
		n = 0;
		@(posedge clk_sys) supply <= 1'b0;
		while (sys_rst_n !== 1'b0 && n < 8) begin
			tick();
			n++;
		end
		`CHECK_EQ("sys_rst_n on low supply", 1'b0, sys_rst_n)
		repeat (4) tick();
		`CHECK_EQ("cfg_regs in hold", DEF, cfg_regs)
		@(posedge clk_sys) supply <= 1'b1;
	endtask : t_supply_drop

	// otp never answers: watchdog ends init near its bound, defaults stay
	task automatic t_init_abort();
		int n;
		n = 0;
		@(posedge clk_sys) supply <= 1'b0;
		@(posedge clk_sys) mute <= 1'b1;
		repeat (8) tick();
		@(posedge clk_sys) supply <= 1'b1;
		while (status.init_done !== 1'b1 && n < 4300) begin
			tick();
			n++;
		end
		`CHECK_EQ("abort within bound", 1'b1, n >= 4000 && n <= 4075)
		`CHECK_EQ("init_err on abort", 1'b1, status.init_err)
		`CHECK_EQ("cfg kept defaults", DEF, cfg_regs)
		`CHECK_EQ("otp_rd after abort", 1'b0, otp_rd)
		`CHECK_EQ("sleeping after abort", 1'b1, status.sleeping)
		@(posedge clk_sys) mute <= 1'b0;
	endtask : t_init_abort

	// bound is several times the expected run
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		summarize();
	end

	initial begin
		arst_n    = 1'b0;
		supply    = 1'b1;
		func_busy = 1'b0;
		slow      = 1'b0;
		mute      = 1'b0;
		pull_low  = 2'b00;
		t_reset_defaults();
		t_init(1'b0);
		t_wake(0);
		t_idle_sleep(0);
		t_wake(1);
		t_idle_sleep(10);
		t_supply_drop();
		t_init(1'b1);
		t_init_abort();
		summarize();
	end
endmodule : power_sleep_reset_sequencer_test
